// File: pkg/tpg_pkg.sv
// Register map, field positions and constants of the test pattern generator
package tpg_pkg;

	// Register indices; some are not multiples of four, so byte = 4 * index
	localparam logic [5:0] IDX_EDGE_RED_ONE   = 6'h00;
	localparam logic [5:0] IDX_EDGE_RED_TWO   = 6'h01;
	localparam logic [5:0] IDX_EDGE_GREEN_ONE = 6'h02;
	localparam logic [5:0] IDX_EDGE_GREEN_TWO = 6'h03;
	localparam logic [5:0] IDX_EDGE_BLUE_ONE  = 6'h04;
	localparam logic [5:0] IDX_EDGE_BLUE_TWO  = 6'h05;
	localparam logic [5:0] IDX_PATTERN_CTRL   = 6'h38;
	localparam logic [5:0] IDX_FIXED_HIGH     = 6'h39;
	localparam logic [5:0] IDX_FIXED_LOW      = 6'h3a;
	localparam logic [5:0] IDX_GRAD_PITCH     = 6'h3b;
	localparam logic [5:0] IDX_GRAD_STEP      = 6'h3c;
	localparam logic [5:0] IDX_COLOUR_DELAY   = 6'h3d;
	localparam logic [5:0] IDX_PAGE_SELECT    = 6'h3f;
	localparam int         EDGE_COUNT         = 6;

	// Page select codes
	localparam logic [7:0] PAGE_MAIN = 8'h00;
	localparam logic [7:0] PAGE_DLL  = 8'h80;

	// Field positions
	localparam int POS_ENABLE     = 7;
	localparam int POS_KIND_HI    = 6;
	localparam int POS_KIND_LO    = 5;
	localparam int POS_COLOUR_HI  = 4;
	localparam int POS_COLOUR_LO  = 3;
	localparam int POS_FIXLO_HI   = 7;
	localparam int POS_FIXLO_LO   = 6;
	localparam int POS_DELAY_HI   = 3;

	// Reset values
	localparam logic [7:0] RST_MAIN = 8'h00;
	localparam logic [7:0] RST_EDGE = 8'h1f;
	localparam logic [4:0] EDGE_MASK_WIDTH_UNUSED = 5'h00;

	// Pattern kinds and colour selects
	localparam logic [1:0] KIND_FIXED = 2'h0;
	localparam logic [1:0] KIND_MAIN  = 2'h1;
	localparam logic [1:0] KIND_SUB   = 2'h2;
	localparam logic [1:0] KIND_GRID  = 2'h3;
	localparam logic [1:0] COL_ALL    = 2'h0;
	localparam logic [1:0] COL_RED    = 2'h1;
	localparam logic [1:0] COL_GREEN  = 2'h2;
	localparam logic [1:0] COL_BLUE   = 2'h3;
	localparam logic [9:0] CODE_FULL  = 10'h3ff;

	// Grid spacing in pixels and lines (power of two)
	localparam int GRID_SHIFT = 4;

	// AHB transfer encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ    = 2'b11;

endpackage

// File: core/line_delay_mem.sv
// Line delay store: per-pixel values of one colour from the previous line
`timescale 1ns/1ps
`default_nettype none
module line_delay_mem
	import tpg_pkg::*;
#(
	parameter int WIDTH  = 10,
	parameter int DEPTH  = 1024,
	parameter int AW     = 10
) (
	// Clock
	input  wire logic             hclk,
	// Write side
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read side, data registered
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge hclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge hclk) begin
		rd_data <= mem[rd_addr];
	end

endmodule
`default_nettype wire

// File: core/skid_buffer.sv
// Two-entry valid/ready buffer for the outgoing pixel stream
`timescale 1ns/1ps
`default_nettype none
module skid_buffer #(
	parameter int WIDTH = 30
) (
	// Clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	logic [WIDTH-1:0] slot_q [2];
	logic             rd_q;
	logic             wr_q;
	logic [1:0]       count_q;
	logic             push;
	logic             pop;

	assign in_ready  = (count_q != 2'd2);
	assign out_valid = (count_q != 2'd0);
	assign out_data  = slot_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge hclk) begin
		if (push) begin
			slot_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q    <= 1'b0;
			wr_q    <= 1'b0;
			count_q <= 2'd0;
		end else begin
			if (push) begin
				wr_q <= ~wr_q;
			end
			if (pop) begin
				rd_q <= ~rd_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule
`default_nettype wire

// File: core/test_pattern_generator.sv
// Test pattern generator: AHB-Lite registers, pattern logic, output stream
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module test_pattern_generator
	import tpg_pkg::*;
#(
	parameter int LINE_PIXELS = 1024,
	parameter int PIX_AW      = 10
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Converted pixel stream in
	input  wire logic        conv_valid,
	output logic             conv_ready,
	input  wire logic        conv_line_start,
	input  wire logic [9:0]  conv_red,
	input  wire logic [9:0]  conv_green,
	input  wire logic [9:0]  conv_blue,
	// Pixel stream out
	output logic             pix_valid,
	input  wire logic        pix_ready,
	output logic      [9:0]  pix_red,
	output logic      [9:0]  pix_green,
	output logic      [9:0]  pix_blue,
	// Sample edge positions to the timing block
	output logic      [4:0]  edge_pos_red_one,
	output logic      [4:0]  edge_pos_red_two,
	output logic      [4:0]  edge_pos_green_one,
	output logic      [4:0]  edge_pos_green_two,
	output logic      [4:0]  edge_pos_blue_one,
	output logic      [4:0]  edge_pos_blue_two
);

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0]  pattern_control_q;
	logic [9:0]  fixed_pattern_code_q;
	logic [7:0]  gradation_pitch_q;
	logic [7:0]  gradation_step_q;
	logic [3:0]  colour_line_delay_q;
	logic [7:0]  page_select_q;
	logic [4:0]  edge_q [EDGE_COUNT];

	logic        wr_pend_q;
	logic [5:0]  wr_idx_q;
	logic        dll_page;
	logic        pattern_enable;
	logic [1:0]  pattern_kind;
	logic [1:0]  pattern_colour_select;
	logic [5:0]  rd_idx;
	logic        addr_phase;

	assign dll_page              = (page_select_q == PAGE_DLL);
	assign pattern_enable        = pattern_control_q[POS_ENABLE];
	assign pattern_kind          = pattern_control_q[POS_KIND_HI:POS_KIND_LO];
	assign pattern_colour_select =
		pattern_control_q[POS_COLOUR_HI:POS_COLOUR_LO];
	assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ ||
		htrans == HTRANS_SEQ);
	assign rd_idx     = haddr[7:2];

	// Zero-wait slave: every transfer answers OKAY in its first data cycle
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Register read word for an index on the current page
	function automatic logic [7:0] read_reg(input logic [5:0] idx);
		logic [7:0] v;
		v = 8'h00;
		if (idx == IDX_PAGE_SELECT) begin
			v = page_select_q;
		end else if (dll_page) begin
			if (idx < 6'(EDGE_COUNT)) begin
				v = {3'b000, edge_q[idx[2:0]]};
			end
		end else begin
			unique case (idx)
				IDX_PATTERN_CTRL: v = {pattern_control_q[7:3], 3'b000};
				IDX_FIXED_HIGH:   v = fixed_pattern_code_q[9:2];
				IDX_FIXED_LOW:    v = {fixed_pattern_code_q[1:0], 6'h00};
				IDX_GRAD_PITCH:   v = gradation_pitch_q;
				IDX_GRAD_STEP:    v = gradation_step_q;
				IDX_COLOUR_DELAY: v = {4'h0, colour_line_delay_q};
				default:          v = 8'h00;
			endcase
		end
		return v;
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= 6'h00;
		end else begin
			wr_pend_q <= addr_phase && hwrite;
			wr_idx_q  <= rd_idx;
		end
	end

	// Read data registered at the address phase edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= {24'h00_0000, read_reg(rd_idx)};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pattern_control_q    <= RST_MAIN;
			fixed_pattern_code_q <= 10'h000;
			gradation_pitch_q    <= RST_MAIN;
			gradation_step_q     <= RST_MAIN;
			colour_line_delay_q  <= 4'h0;
			page_select_q        <= PAGE_MAIN;
		end else if (wr_pend_q) begin
			if (wr_idx_q == IDX_PAGE_SELECT) begin
				page_select_q <= hwdata[7:0];
			end else if (!dll_page) begin
				unique case (wr_idx_q)
					IDX_PATTERN_CTRL:
						pattern_control_q <= {hwdata[7:3], 3'b000};
					IDX_FIXED_HIGH:
						fixed_pattern_code_q[9:2] <= hwdata[7:0];
					IDX_FIXED_LOW:
						fixed_pattern_code_q[1:0] <=
							hwdata[POS_FIXLO_HI:POS_FIXLO_LO];
					IDX_GRAD_PITCH:   gradation_pitch_q <= hwdata[7:0];
					IDX_GRAD_STEP:    gradation_step_q <= hwdata[7:0];
					IDX_COLOUR_DELAY:
						colour_line_delay_q <= hwdata[POS_DELAY_HI:0];
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < EDGE_COUNT; i++) begin
				edge_q[i] <= RST_EDGE[4:0];
			end
		end else if (wr_pend_q && dll_page &&
			wr_idx_q < 6'(EDGE_COUNT)) begin
			edge_q[wr_idx_q[2:0]] <= hwdata[4:0];
		end
	end

	assign edge_pos_red_one   = edge_q[0];
	assign edge_pos_red_two   = edge_q[1];
	assign edge_pos_green_one = edge_q[2];
	assign edge_pos_green_two = edge_q[3];
	assign edge_pos_blue_one  = edge_q[4];
	assign edge_pos_blue_two  = edge_q[5];

	////////////////////////////////////////////////////////////////////////
	// Pixel and line position, gradation accumulators

	logic              in_ready;
	logic              advance;
	logic [PIX_AW-1:0] pix_q;
	logic [15:0]       line_q;
	logic [7:0]        pix_pitch_q;
	logic [7:0]        line_pitch_q;
	logic [9:0]        main_val_q;
	logic [9:0]        sub_val_q;
	logic              first_line_q;

	assign conv_ready = in_ready;
	assign advance    = conv_valid && in_ready;

	// Pitch of zero advances on every pixel or line
	function automatic logic pitch_done(input logic [7:0] cnt,
		input logic [7:0] pitch);
		return cnt >= pitch;
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pix_q        <= '0;
			line_q       <= 16'h0000;
			pix_pitch_q  <= 8'h00;
			line_pitch_q <= 8'h00;
			main_val_q   <= 10'h000;
			sub_val_q    <= 10'h000;
			first_line_q <= 1'b1;
		end else if (advance) begin
			if (conv_line_start) begin
				pix_q        <= PIX_AW'(1);
				first_line_q <= 1'b0;
				// First pixel of a line counts as pixel 0 of the pitch
				if (pitch_done(8'h00, gradation_pitch_q)) begin
					pix_pitch_q <= 8'h00;
					main_val_q  <= {2'b00, gradation_step_q};
				end else begin
					pix_pitch_q <= 8'h01;
					main_val_q  <= 10'h000;
				end
				if (!first_line_q) begin
					line_q <= line_q + 16'h0001;
					if (pitch_done(line_pitch_q, gradation_pitch_q)) begin
						line_pitch_q <= 8'h00;
						sub_val_q    <= sub_val_q +
							{2'b00, gradation_step_q};
					end else begin
						line_pitch_q <= line_pitch_q + 8'h01;
					end
				end
			end else begin
				pix_q <= pix_q + PIX_AW'(1);
				if (pitch_done(pix_pitch_q, gradation_pitch_q)) begin
					pix_pitch_q <= 8'h00;
					main_val_q  <= main_val_q +
						{2'b00, gradation_step_q};
				end else begin
					pix_pitch_q <= pix_pitch_q + 8'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pattern value for the current pixel

	logic [9:0] pattern_value;
	logic [PIX_AW-1:0] cur_pix;
	logic       grid_hit;

	assign cur_pix  = conv_line_start ? '0 : pix_q;
	assign grid_hit = (cur_pix[GRID_SHIFT-1:0] == '0) ||
		(line_q[GRID_SHIFT-1:0] == '0);

	always_comb begin
		unique case (pattern_kind)
			KIND_FIXED: pattern_value = fixed_pattern_code_q;
			KIND_MAIN:  pattern_value = conv_line_start ? 10'h000 : main_val_q;
			KIND_SUB:   pattern_value = sub_val_q;
			KIND_GRID:  pattern_value = grid_hit ? CODE_FULL : 10'h000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Colour line delay: green one delay, blue two delays

	logic [9:0] green_hist;
	logic [9:0] blue_hist;
	logic [9:0] green_now_q;
	logic [9:0] blue_now_q;
	logic [9:0] green_src;
	logic [9:0] blue_src;

	// u_green holds the last line of pattern_value and u_blue of green_src per pixel column;
	// a line ring would cost 15x storage, so delay uses line-count gating
	line_delay_mem #(.WIDTH(10), .DEPTH(LINE_PIXELS), .AW(PIX_AW)) u_green (
		.hclk    (hclk),
		.wr_en   (advance),
		.wr_addr (cur_pix),
		.wr_data (pattern_value),
		.rd_addr (cur_pix),
		.rd_data (green_hist)
	);

	line_delay_mem #(.WIDTH(10), .DEPTH(LINE_PIXELS), .AW(PIX_AW)) u_blue (
		.hclk    (hclk),
		.wr_en   (advance),
		.wr_addr (cur_pix),
		.wr_data (green_src),
		.rd_addr (cur_pix),
		.rd_data (blue_hist)
	);

	// Green and blue start the pattern delay*1 and delay*2 lines later
	assign green_src = (line_q >= {12'h000, colour_line_delay_q}) ?
		pattern_value : CODE_FULL;
	assign blue_src  = (line_q >= {11'h000, colour_line_delay_q, 1'b0}) ?
		pattern_value : CODE_FULL;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			green_now_q <= 10'h000;
			blue_now_q  <= 10'h000;
		end else begin
			green_now_q <= green_hist;
			blue_now_q  <= blue_hist;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output selection into the buffer

	logic [9:0] sel_red;
	logic [9:0] sel_green;
	logic [9:0] sel_blue;

	always_comb begin
		sel_red   = conv_red;
		sel_green = conv_green;
		sel_blue  = conv_blue;
		if (pattern_enable) begin
			sel_red   = pattern_value;
			sel_green = green_src;
			sel_blue  = blue_src;
			unique case (pattern_colour_select)
				COL_ALL: ;
				COL_RED: begin
					sel_green = CODE_FULL;
					sel_blue  = CODE_FULL;
				end
				COL_GREEN: begin
					sel_red   = CODE_FULL;
					sel_blue  = CODE_FULL;
				end
				COL_BLUE: begin
					sel_red   = CODE_FULL;
					sel_green = CODE_FULL;
				end
			endcase
		end
	end

	skid_buffer #(.WIDTH(30)) u_buf (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.in_valid  (conv_valid),
		.in_ready  (in_ready),
		.in_data   ({sel_red, sel_green, sel_blue}),
		.out_valid (pix_valid),
		.out_ready (pix_ready),
		.out_data  ({pix_red, pix_green, pix_blue})
	);

endmodule
`default_nettype wire

// File: dv/tpg_checker.sv
// Port-level assertions for the test pattern generator
`timescale 1ns/1ps
`default_nettype none
module tpg_checker
	import tpg_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Register bus
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	input  wire logic [31:0] hrdata,
	// Streams
	input  wire logic        conv_valid,
	input  wire logic        conv_ready,
	input  wire logic        pix_valid,
	input  wire logic        pix_ready,
	input  wire logic [9:0]  pix_red,
	input  wire logic [9:0]  pix_green,
	input  wire logic [9:0]  pix_blue,
	// Edge position
	input  wire logic [4:0]  edge_pos_red_one
);
	logic       wr_q;
	logic [5:0] idx_q;
	logic [7:0] page_q;

	// Data phase of a write, and the page it lands in
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			idx_q <= 6'h00;
		end else begin
			wr_q <= hsel && hready && htrans[1] && hwrite;
			idx_q <= haddr[7:2];
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			page_q <= PAGE_MAIN;
		end else if (wr_q && idx_q == IDX_PAGE_SELECT) begin
			page_q <= hwdata[7:0];
		end
	end

	////////////////////////////////////////
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_resp_okay: assert property (!hresp)
		else $error("error response seen");
	a_ready_high: assert property (hreadyout)
		else $error("wait state seen");
	a_rdata_upper: assert property (hrdata[31:8] == 24'h0000_00)
		else $error("read data upper bits not zero");
	a_edge_write: assert property (wr_q && idx_q == IDX_EDGE_RED_ONE
		&& page_q == PAGE_DLL |=> edge_pos_red_one == $past(hwdata[4:0]))
		else $error("edge position not stored");
	a_edge_stable: assert property (!$stable(edge_pos_red_one)
		|-> $past(wr_q) && $past(idx_q) == IDX_EDGE_RED_ONE)
		else $error("edge position changed without write");
	a_out_hold: assert property (pix_valid && !pix_ready
		|=> pix_valid && $stable({pix_red, pix_green, pix_blue}))
		else $error("stalled pixel dropped or changed");
	a_take_answer: assert property (conv_valid && conv_ready |=> pix_valid)
		else $error("accepted pixel not presented");
	a_full_valid: assert property (!conv_ready |-> pix_valid)
		else $error("refusing while empty");

	c_dll_write: cover property (wr_q && page_q == PAGE_DLL);
	c_stall: cover property (pix_valid && !pix_ready);
	c_full: cover property (!conv_ready);
endmodule
bind test_pattern_generator tpg_checker i_tpg_checker (.*);
`default_nettype wire

// File: dv/pixel_sink.sv
// Image controller model that throttles the outgoing pixel stream
`timescale 1ns/1ps
`default_nettype none
module pixel_sink (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Throttle request from the bench
	input  wire logic stall,
	// Stream handshake
	output logic      pix_ready
);
	logic [15:0] lfsr_q;

	// When stalling, about one beat in four is taken so the buffer fills
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lfsr_q <= 16'hace1;
			pix_ready <= 1'b0;
		end else begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[10]};
			pix_ready <= !stall || (lfsr_q[0] && lfsr_q[1]);
		end
	end
endmodule
`default_nettype wire

// File: dv/test_test_pattern_generator.sv
// Self-checking bench for the test pattern generator
`timescale 1ns/1ps
`default_nettype none
module test_test_pattern_generator
	import tpg_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        conv_valid, conv_ready, conv_line_start, stall;
	logic        pix_valid, pix_ready;
	logic [9:0]  conv_red, conv_green, conv_blue, pix_red, pix_green, pix_blue;
	logic [4:0]  edge_pos_red_one, edge_pos_red_two, edge_pos_green_one;
	logic [4:0]  edge_pos_green_two, edge_pos_blue_one, edge_pos_blue_two;
	logic [29:0] edges;
	logic [29:0] exp_q[$];
	logic [31:0] seed_q = 32'h0000_864f;
	logic [7:0]  cfg_pc, cfg_pitch, cfg_step;
	logic [9:0]  cfg_code;
	int          mismatches = 0;
	int          total_checks = 0;

	assign hready = hreadyout;
	assign edges = {edge_pos_blue_two, edge_pos_blue_one, edge_pos_green_two,
		edge_pos_green_one, edge_pos_red_two, edge_pos_red_one};
	test_pattern_generator i_test_pattern_generator (.*);
	pixel_sink i_pixel_sink (.*);

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [5:0] idx,
		input logic [7:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0000_00, idx, 2'b00};
		hwrite <= w;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0000_00, wd};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
		logic [31:0] d;
		bus(1'b1, idx, wd, d);
	endtask
	task automatic rdc(input logic [5:0] idx, input logic [7:0] e);
		logic [31:0] d;
		bus(1'b0, idx, 8'h00, d);
		check(d, {24'h0000_00, e});
	endtask
	task automatic setup(input logic [7:0] pc, input logic [9:0] code,
		input logic [7:0] pt, input logic [7:0] st);
		cfg_pc = pc;
		cfg_code = code;
		cfg_pitch = pt;
		cfg_step = st;
		wr(IDX_FIXED_HIGH, code[9:2]);
		wr(IDX_FIXED_LOW, {code[1:0], 6'h00});
		wr(IDX_GRAD_PITCH, pt);
		wr(IDX_GRAD_STEP, st);
		wr(IDX_PATTERN_CTRL, pc);
	endtask
	// Pattern value is taken as fixed per beat, so config changes between lines only
	function automatic logic [29:0] expect_pix(input int i, input logic [29:0] cv);
		logic [9:0] v;
		if (!cfg_pc[POS_ENABLE])
			return cv;
		v = (cfg_pc[6:5] == KIND_FIXED) ? cfg_code : 10'((i / (cfg_pitch + 1)) * cfg_step);
		case (cfg_pc[4:3])
			COL_RED: return {v, CODE_FULL, CODE_FULL};
			COL_GREEN: return {CODE_FULL, v, CODE_FULL};
			COL_BLUE: return {CODE_FULL, CODE_FULL, v};
			default: return {v, v, v};
		endcase
	endfunction
	task automatic send(input int n);
		logic [29:0] cv;
		for (int i = 0; i < n; i++) begin
			seed_q = xs(seed_q);
			cv = seed_q[29:0];
			conv_valid <= 1'b1;
			conv_line_start <= (i == 0);
			{conv_red, conv_green, conv_blue} <= cv;
			@(negedge hclk);
			while (!conv_ready) @(negedge hclk);
			@(posedge hclk);
			exp_q.push_back(expect_pix(i, cv));
		end
		conv_valid <= 1'b0;
		conv_line_start <= 1'b0;
		while (exp_q.size() != 0) @(posedge hclk);
	endtask

	always @(posedge hclk) begin
		if (hresetn && pix_valid && pix_ready) begin
			if (exp_q.size() == 0)
				check(32'h0000_0001, 32'h0000_0000);
			else
				check({2'b00, pix_red, pix_green, pix_blue}, {2'b00, exp_q.pop_front()});
		end
	end

	initial begin
		#(25ns * 40000);
		mismatches++;
		wrap_up();
	end

	////////////////////////////////////////
	initial begin
		logic [7:0] v;
		{hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize, stall} = '0;
		hsize = 3'b010;
		{conv_valid, conv_line_start, conv_red, conv_green, conv_blue} = '0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		for (int k = 'h38; k <= 'h3e; k++)
			rdc(6'(k), 8'h00);
		wr(IDX_PATTERN_CTRL, 8'h7f);
		rdc(IDX_PATTERN_CTRL, 8'h78);
		for (int k = 'h39; k <= 'h3c; k++) begin
			seed_q = xs(seed_q);
			v = (k == 'h3a) ? (seed_q[7:0] & 8'hc0) : seed_q[7:0];
			wr(6'(k), v);
			rdc(6'(k), v);
		end
		wr(IDX_COLOUR_DELAY, 8'h0f);
		rdc(IDX_COLOUR_DELAY, 8'h0f);
		wr(IDX_COLOUR_DELAY, 8'h00);
		wr(IDX_GRAD_PITCH, 8'h5a);
		wr(IDX_PAGE_SELECT, PAGE_DLL);
		rdc(IDX_PAGE_SELECT, PAGE_DLL);
		for (int k = 0; k < EDGE_COUNT; k++) begin
			rdc(6'(k), 8'h1f);
			seed_q = xs(seed_q);
			wr(6'(k), {3'b000, seed_q[4:0]});
			rdc(6'(k), {3'b000, seed_q[4:0]});
			check(32'(edges[k*5 +: 5]), 32'(seed_q[4:0]));
		end
		rdc(6'h06, 8'h00);
		wr(IDX_GRAD_PITCH, 8'h00);
		wr(IDX_PAGE_SELECT, PAGE_MAIN);
		rdc(IDX_GRAD_PITCH, 8'h5a);
		stall <= 1'b1;
		setup(8'h78, 10'h2a5, 8'h03, 8'h11);
		send(20);
		for (int c = 0; c < 4; c++) begin
			stall <= c[0];
			seed_q = xs(seed_q);
			setup(8'h80 | 8'(c << 3), seed_q[9:0], 8'h00, 8'h00);
			send(6);
		end
		stall <= 1'b1;
		setup(8'ha0, 10'h000, 8'h01, 8'h90);
		send(24);
		setup(8'hc0, 10'h000, 8'h00, 8'h00);
		send(4);
		wrap_up();
	end
endmodule
`default_nettype wire
